// File: core/asb_alu.sv
// Result and flag computation for one core instruction.
// Purely combinational; the caller registers whatever it keeps.
`timescale 1ns/1ps
module asb_alu (
	input wire asb_pkg::asb_op_t op,
	input wire logic [7:0] w,
	input wire logic [7:0] f,
	input wire logic [2:0] bit_sel,
	input wire logic carry_in,
	output logic [7:0] res,
	output logic z,
	output logic dcarry,
	output logic c,
	output logic aff_z,
	output logic aff_c
);
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] bmask;

	always_comb begin
		sum = 9'h000;
		nib = 5'h00;
		bmask = 8'h01 << bit_sel;
		res = f;
		c = carry_in;
		aff_z = 1'b1;
		aff_c = 1'b0;
		case (op)
			asb_pkg::ASB_OP_ADD: begin
				sum = {1'b0, w} + {1'b0, f};
				nib = {1'b0, w[3:0]} + {1'b0, f[3:0]};
				res = sum[7:0];
				c = sum[8];
				aff_c = 1'b1;
			end
			asb_pkg::ASB_OP_SUB: begin
				// Two's complement add, so carry high means no borrow
				sum = {1'b0, f} + {1'b0, ~w} + 9'h001;
				nib = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
				res = sum[7:0];
				c = sum[8];
				aff_c = 1'b1;
			end
			asb_pkg::ASB_OP_AND: res = w & f;
			asb_pkg::ASB_OP_IOR: res = w | f;
			asb_pkg::ASB_OP_XOR: res = w ^ f;
			asb_pkg::ASB_OP_CLEAR: res = 8'h00;
			asb_pkg::ASB_OP_ROTL: begin
				res = {f[6:0], carry_in};
				c = f[7];
				aff_z = 1'b0;
				aff_c = 1'b1;
			end
			asb_pkg::ASB_OP_ROTR: begin
				res = {carry_in, f[7:1]};
				c = f[0];
				aff_z = 1'b0;
				aff_c = 1'b1;
			end
			asb_pkg::ASB_OP_SWAP: begin
				res = {f[3:0], f[7:4]};
				aff_z = 1'b0;
			end
			asb_pkg::ASB_OP_BITCLR: begin
				res = f & ~bmask;
				aff_z = 1'b0;
			end
			asb_pkg::ASB_OP_BITSET: begin
				res = f | bmask;
				aff_z = 1'b0;
			end
			asb_pkg::ASB_OP_MOVE: begin
				res = w;
				aff_z = 1'b0;
			end
			default: res = f;
		endcase
		z = (res == 8'h00);
		dcarry = nib[4];
	end
endmodule

// File: core/asb_pkg.sv
// Constants and types for the arithmetic status and bank select register bank.
// Assumes a single 50 MHz clock and an AHB-Lite bus with 32-bit data.
package asb_pkg;

	// Register indexes; byte address is four times the index
	localparam logic [7:0] ASB_IDX_STATUS = 8'h03;
	localparam logic [7:0] ASB_IDX_PCHOLD = 8'h0a;
	localparam logic [6:0] ASB_IDX_MASK = 7'h7f;

	// Status bit positions
	localparam int ASB_B_INDIRECT = 7;
	localparam int ASB_B_DIR_HI = 6;
	localparam int ASB_B_DIR_LO = 5;
	localparam int ASB_B_TIMEOUT = 4;
	localparam int ASB_B_PWRDN = 3;
	localparam int ASB_B_ZERO = 2;
	localparam int ASB_B_DCARRY = 1;
	localparam int ASB_B_CARRY = 0;

	// Values after power-on reset
	localparam logic [7:0] ASB_STATUS_POR = 8'h18;
	localparam logic [4:0] ASB_PCHOLD_POR = 5'h00;

	// Data locations below this are mirrored in every bank
	localparam logic [6:0] ASB_COMMON_LIMIT = 7'h0c;

	// AHB encodings
	localparam logic [1:0] ASB_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] ASB_HRESP_OKAY = 2'h0;

	typedef enum logic [3:0] {
		ASB_OP_MOVE = 4'h0,
		ASB_OP_ADD = 4'h1,
		ASB_OP_SUB = 4'h2,
		ASB_OP_AND = 4'h3,
		ASB_OP_IOR = 4'h4,
		ASB_OP_XOR = 4'h5,
		ASB_OP_ROTL = 4'h6,
		ASB_OP_ROTR = 4'h7,
		ASB_OP_CLEAR = 4'h8,
		ASB_OP_SWAP = 4'h9,
		ASB_OP_BITCLR = 4'ha,
		ASB_OP_BITSET = 4'hb
	} asb_op_t;

endpackage

// File: core/asb_top.sv
// Arithmetic status and bank select register with its bank mapping and PC upper latch.
// Assumes an AHB-Lite master on hclk and a core decoder that pulses one instruction per cycle.
`timescale 1ns/1ps
module asb_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic [1:0] hresp,
	input wire logic core_op_valid,
	input wire asb_pkg::asb_op_t core_op,
	input wire logic [7:0] core_w,
	input wire logic [7:0] core_f,
	input wire logic [2:0] core_bit_sel,
	input wire logic core_dest_status,
	input wire logic core_wdt_clear,
	input wire logic core_sleep,
	input wire logic core_wdt_timeout,
	input wire logic core_wdt_reset,
	input wire logic master_clear_pin_n,
	input wire logic core_pc_load,
	input wire logic [6:0] core_dir_addr,
	input wire logic [7:0] core_fsr,
	output logic [7:0] status,
	output logic [7:0] core_result,
	output logic [8:0] dmem_dir_addr,
	output logic [8:0] dmem_ind_addr,
	output logic [4:0] pc_upper
);
	// Mirrored special locations ignore the bank bits
	function automatic logic asb_common(input logic [6:0] a);
		return a < asb_pkg::ASB_COMMON_LIMIT;
	endfunction

	function automatic logic asb_is(input logic [7:0] idx, input logic [7:0] reg_idx);
		return (idx[6:0] & asb_pkg::ASB_IDX_MASK) == reg_idx[6:0];
	endfunction

	logic [7:0] status_r, status_nxt;
	logic [4:0] pchold_r;
	logic [4:0] pc_upper_r;
	logic [7:0] result_r;
	logic [8:0] dir_addr_r, ind_addr_r;
	logic [31:0] hrdata_r;
	logic hreadyout_r;
	logic wr_pend_r;
	logic [7:0] wr_idx_r;
	logic pinclr_s1_r, pinclr_s2_r;

	// Pin clear passes two flops before use
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pinclr_s1_r <= 1'b1;
			pinclr_s2_r <= 1'b1;
		end else begin
			pinclr_s1_r <= master_clear_pin_n;
			pinclr_s2_r <= pinclr_s1_r;
		end
	end

	wire other_reset = !pinclr_s2_r || core_wdt_reset;

	// Bus decode
	wire [7:0] a_idx = haddr[9:2];
	wire a_take = hsel && hready && (htrans == asb_pkg::ASB_HTRANS_NONSEQ);
	wire a_read = a_take && !hwrite;
	wire a_write = a_take && hwrite;
	wire wr_status = wr_pend_r && asb_is(wr_idx_r, asb_pkg::ASB_IDX_STATUS);
	wire wr_pchold = wr_pend_r && asb_is(wr_idx_r, asb_pkg::ASB_IDX_PCHOLD);
	wire [31:0] rd_val = asb_is(a_idx, asb_pkg::ASB_IDX_STATUS) ? {24'h000000, status_r} :
		asb_is(a_idx, asb_pkg::ASB_IDX_PCHOLD) ? {27'h0000000, pchold_r} : 32'h00000000;

	// Instruction flags
	wire [7:0] alu_res;
	wire alu_z, alu_dcarry, alu_c, alu_fz, alu_fc;

	asb_alu u_alu (
		.op(core_op),
		.w(core_w),
		.f(core_f),
		.bit_sel(core_bit_sel),
		.carry_in(status_r[asb_pkg::ASB_B_CARRY]),
		.res(alu_res),
		.z(alu_z),
		.dcarry(alu_dcarry),
		.c(alu_c),
		.aff_z(alu_fz),
		.aff_c(alu_fc)
	);

	wire op_flags = core_op_valid && (alu_fz || alu_fc);
	wire op_wr = core_op_valid && core_dest_status;
	// Bank bits always take the data; bits 2:0 take it only when the instruction affects no flag; status bits 4:3 never do
	wire [7:0] op_wmask = op_flags ? 8'he0 : 8'he7;
	wire [7:0] bus_wmask = 8'he7;

	always_comb begin
		status_nxt = status_r;
		if (wr_status) begin
			status_nxt = (status_nxt & ~bus_wmask) | (hwdata[7:0] & bus_wmask);
		end
		// Core wins over a bus write in the same cycle
		if (op_wr) begin
			status_nxt = (status_nxt & ~op_wmask) | (alu_res & op_wmask);
		end
		if (core_op_valid && alu_fz) begin
			status_nxt[asb_pkg::ASB_B_ZERO] = alu_z;
		end
		if (core_op_valid && alu_fc) begin
			status_nxt[asb_pkg::ASB_B_CARRY] = alu_c;
			if (core_op == asb_pkg::ASB_OP_ADD || core_op == asb_pkg::ASB_OP_SUB) begin
				status_nxt[asb_pkg::ASB_B_DCARRY] = alu_dcarry;
			end
		end
		if (core_wdt_clear) begin
			status_nxt[asb_pkg::ASB_B_TIMEOUT] = 1'b1;
			status_nxt[asb_pkg::ASB_B_PWRDN] = 1'b1;
		end
		if (core_sleep) begin
			status_nxt[asb_pkg::ASB_B_TIMEOUT] = 1'b1;
			status_nxt[asb_pkg::ASB_B_PWRDN] = 1'b0;
		end
		// A time-out must never be hidden by a coincident clear
		if (core_wdt_timeout) begin
			status_nxt[asb_pkg::ASB_B_TIMEOUT] = 1'b0;
		end
		if (other_reset) begin
			status_nxt[7:5] = 3'h0;
		end
	end

	wire [8:0] dir_nxt = asb_common(core_dir_addr) ? {2'h0, core_dir_addr} :
		{status_r[asb_pkg::ASB_B_DIR_HI:asb_pkg::ASB_B_DIR_LO], core_dir_addr};
	wire [8:0] ind_nxt = asb_common(core_fsr[6:0]) ? {2'h0, core_fsr[6:0]} :
		{status_r[asb_pkg::ASB_B_INDIRECT], core_fsr};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_r <= asb_pkg::ASB_STATUS_POR;
			pchold_r <= asb_pkg::ASB_PCHOLD_POR;
			pc_upper_r <= asb_pkg::ASB_PCHOLD_POR;
			result_r <= 8'h00;
			dir_addr_r <= 9'h000;
			ind_addr_r <= 9'h000;
		end else begin
			status_r <= status_nxt;
			if (other_reset) begin
				pchold_r <= asb_pkg::ASB_PCHOLD_POR;
			end else if (wr_pchold) begin
				pchold_r <= hwdata[4:0];
			end
			if (core_pc_load) begin
				pc_upper_r <= pchold_r;
			end
			if (core_op_valid) begin
				result_r <= alu_res;
			end
			dir_addr_r <= dir_nxt;
			ind_addr_r <= ind_nxt;
		end
	end

	// Zero wait state slave; a read right after a write to the same word sees the old value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h00000000;
			hreadyout_r <= 1'b1;
			wr_pend_r <= 1'b0;
			wr_idx_r <= 8'h00;
		end else begin
			hreadyout_r <= 1'b1;
			wr_pend_r <= a_write;
			if (a_write) begin
				wr_idx_r <= a_idx;
			end
			if (a_read) begin
				hrdata_r <= rd_val;
			end
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = asb_pkg::ASB_HRESP_OKAY;
	assign status = status_r;
	assign core_result = result_r;
	assign dmem_dir_addr = dir_addr_r;
	assign dmem_ind_addr = ind_addr_r;
	assign pc_upper = pc_upper_r;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	wire no_hw_evt = !core_wdt_clear && !core_sleep && !core_wdt_timeout;

	property p_tp_hold;
		no_hw_evt |=> $stable(status_r[4:3]);
	endproperty
	a_tp_hold: assert property (p_tp_hold) else $error("timeout or power-down changed without event");

	property p_mask_flags;
		op_wr && op_flags && !alu_fz |=> status_r[2] == $past(status_r[2]);
	endproperty
	a_mask_flags: assert property (p_mask_flags) else $error("data write reached zero flag");

	property p_clear_status;
		op_wr && core_op == asb_pkg::ASB_OP_CLEAR && !other_reset |=>
			status_r[7:5] == 3'h0 && status_r[2] && status_r[1:0] == $past(status_r[1:0]);
	endproperty
	a_clear_status: assert property (p_clear_status) else $error("clear of status gave wrong bits");

	property p_timeout;
		core_wdt_timeout |=> !status_r[4];
	endproperty
	a_timeout: assert property (p_timeout) else $error("time-out flag not cleared");

	property p_sleep_pwrdn;
		core_sleep |=> !status_r[3] && (status_r[4] == !$past(core_wdt_timeout));
	endproperty
	a_sleep_pwrdn: assert property (p_sleep_pwrdn) else $error("sleep flags wrong");

	property p_zero;
		core_op_valid && alu_fz |=> status_r[2] == ($past(alu_res) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_add_carry;
		core_op_valid && core_op == asb_pkg::ASB_OP_ADD |=>
			status_r[0] == ($past(core_w) > (8'hff - $past(core_f)));
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

	property p_sub_borrow;
		core_op_valid && core_op == asb_pkg::ASB_OP_SUB |=>
			status_r[0] == ($past(core_f) >= $past(core_w)) &&
			status_r[1] == ($past(core_f[3:0]) >= $past(core_w[3:0]));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("subtract borrow wrong");

	property p_rotate;
		core_op_valid && core_op == asb_pkg::ASB_OP_ROTL |=> status_r[0] == $past(core_f[7]);
	endproperty
	a_rotate: assert property (p_rotate) else $error("rotate carry wrong");

	property p_dir_bank;
		!asb_common(core_dir_addr) |=> dmem_dir_addr == {$past(status_r[6:5]), $past(core_dir_addr)};
	endproperty
	a_dir_bank: assert property (p_dir_bank) else $error("direct bank mapping wrong");

	property p_ind_bank;
		!asb_common(core_fsr[6:0]) |=> dmem_ind_addr[8] == $past(status_r[7]);
	endproperty
	a_ind_bank: assert property (p_ind_bank) else $error("indirect bank wrong");

	property p_common;
		asb_common(core_dir_addr) |=> dmem_dir_addr[8:7] == 2'h0;
	endproperty
	a_common: assert property (p_common) else $error("special location not mirrored");

	property p_unmapped;
		a_read && !asb_is(a_idx, asb_pkg::ASB_IDX_STATUS) && !asb_is(a_idx, asb_pkg::ASB_IDX_PCHOLD) |=>
			hrdata == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_pc_load;
		core_pc_load |=> pc_upper == $past(pchold_r);
	endproperty
	a_pc_load: assert property (p_pc_load) else $error("pc upper not loaded from latch");

	property p_other_reset;
		other_reset |=> status_r[7:5] == 3'h0;
	endproperty
	a_other_reset: assert property (p_other_reset) else $error("bank bits kept across reset");

	c_clear_status: cover property (op_wr && core_op == asb_pkg::ASB_OP_CLEAR);
	c_sub_status: cover property (op_wr && core_op == asb_pkg::ASB_OP_SUB);
	c_bus_status: cover property (wr_status ##1 a_read);
	c_sleep_wake: cover property (core_sleep ##[1:20] core_wdt_clear);
endmodule

// File: verification/asb_core_model.sv
// Partner model of the core decoder and ALU front end: instructions and events.
// Assumes the caller enters each task right after a rising edge of hclk.
`timescale 1ns/1ps
module asb_core_model (
	input wire logic hclk,
	output logic core_op_valid,
	output asb_pkg::asb_op_t core_op,
	output logic [7:0] core_w,
	output logic [7:0] core_f,
	output logic [2:0] core_bit_sel,
	output logic core_dest_status,
	output logic core_wdt_clear,
	output logic core_sleep,
	output logic core_wdt_timeout,
	output logic core_wdt_reset,
	output logic core_pc_load
);
	logic [4:0] evt;

	assign {core_pc_load, core_wdt_reset, core_wdt_timeout, core_sleep, core_wdt_clear} = evt;

	initial begin
		evt = 5'h00;
		core_op_valid = 1'b0;
		core_op = asb_pkg::ASB_OP_MOVE;
		core_w = 8'h00;
		core_f = 8'h00;
		core_bit_sel = 3'h0;
		core_dest_status = 1'b0;
	end

	// One instruction per pulse; operands scrambled after use so stale values never help
	task automatic exec(input asb_pkg::asb_op_t op, input logic [7:0] w, input logic [7:0] f, input logic d);
		core_op_valid <= 1'b1;
		core_op <= op;
		core_w <= w;
		core_f <= f;
		core_dest_status <= d;
		@(posedge hclk);
		core_op_valid <= 1'b0;
		core_dest_status <= 1'b0;
		core_w <= ~w;
		core_f <= ~f;
	endtask

	// One-cycle event pulse: {pc_load, wdt_reset, timeout, sleep, wdt_clear}
	task automatic pulse(input logic [4:0] m);
		evt <= m;
		@(posedge hclk);
		evt <= 5'h00;
	endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench for the status and bank select register block.
// Assumes one AHB-Lite slave, so hready is the block's own hreadyout.
`timescale 1ns/1ps
module testbench;
	logic hclk, hresetn, hwrite, master_clear_pin_n, hreadyout;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, hresp;
	logic core_op_valid, core_dest_status, core_wdt_clear, core_sleep, core_wdt_timeout, core_wdt_reset, core_pc_load;
	asb_pkg::asb_op_t core_op;
	logic [7:0] core_w, core_f, core_fsr, status, core_result;
	logic [2:0] core_bit_sel;
	logic [6:0] core_dir_addr;
	logic [8:0] dmem_dir_addr, dmem_ind_addr;
	logic [4:0] pc_upper;
	int error_cnt, total_checks;

	asb_top u_asb_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .core_op_valid(core_op_valid), .core_op(core_op),
		.core_w(core_w), .core_f(core_f), .core_bit_sel(core_bit_sel), .core_dest_status(core_dest_status),
		.core_wdt_clear(core_wdt_clear), .core_sleep(core_sleep), .core_wdt_timeout(core_wdt_timeout),
		.core_wdt_reset(core_wdt_reset), .master_clear_pin_n(master_clear_pin_n), .core_pc_load(core_pc_load),
		.core_dir_addr(core_dir_addr), .core_fsr(core_fsr), .status(status), .core_result(core_result),
		.dmem_dir_addr(dmem_dir_addr), .dmem_ind_addr(dmem_ind_addr), .pc_upper(pc_upper));

	asb_core_model u_asb_core_model (.hclk(hclk), .core_op_valid(core_op_valid), .core_op(core_op),
		.core_w(core_w), .core_f(core_f), .core_bit_sel(core_bit_sel), .core_dest_status(core_dest_status),
		.core_wdt_clear(core_wdt_clear), .core_sleep(core_sleep), .core_wdt_timeout(core_wdt_timeout),
		.core_wdt_reset(core_wdt_reset), .core_pc_load(core_pc_load));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Single word transfer; waits on hready rather than assuming zero wait states
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		htrans <= asb_pkg::ASB_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask

	// Idle cycle first: a read right behind a write still sees the old word
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		@(posedge hclk);
		bus(a, 1'b0, 32'h0, q);
		chk(q, exp);
	endtask

	task automatic step(input asb_pkg::asb_op_t op, input logic [7:0] w, input logic [7:0] f, input logic d,
		input logic [7:0] er, input logic [7:0] es);
		u_asb_core_model.exec(op, w, f, d);
		#1;
		chk(core_result, er);
		chk(status, es);
	endtask

	task automatic ev(input logic [4:0] m, input logic [7:0] es);
		u_asb_core_model.pulse(m);
		#1;
		chk(status, es);
	endtask

	task automatic t_reset_bus;
		chk(status, 8'h18);
		chk(hresp, 2'h0);
		rd(32'h0c, 32'h18);
		wr(32'h0c, 32'hff);
		wr(32'h0c, 32'h00);
		#1 chk(status, 8'h18);
		rd(32'h20c, 32'h18);
		rd(32'h10, 32'h0);
		wr(32'h28, 32'hffffffff);
		rd(32'h28, 32'h1f);
		chk(pc_upper, 5'h00);
		ev(5'h10, 8'h18);
		chk(pc_upper, 5'h1f);
		$display("test reset_bus done");
	endtask

	task automatic t_alu;
		step(asb_pkg::ASB_OP_ADD, 8'h0f, 8'h01, 1'b0, 8'h10, 8'h1a);
		step(asb_pkg::ASB_OP_ADD, 8'h01, 8'hff, 1'b0, 8'h00, 8'h1f);
		step(asb_pkg::ASB_OP_SUB, 8'h01, 8'h10, 1'b0, 8'h0f, 8'h19);
		step(asb_pkg::ASB_OP_SUB, 8'h02, 8'h01, 1'b0, 8'hff, 8'h18);
		step(asb_pkg::ASB_OP_XOR, 8'h55, 8'h55, 1'b0, 8'h00, 8'h1c);
		step(asb_pkg::ASB_OP_ROTL, 8'h00, 8'h80, 1'b0, 8'h00, 8'h1d);
		step(asb_pkg::ASB_OP_ROTR, 8'h00, 8'h02, 1'b0, 8'h81, 8'h1c);
		// Data low bits 000 against carry 1 shows the blocked write
		step(asb_pkg::ASB_OP_ADD, 8'h40, 8'he0, 1'b1, 8'h20, 8'h39);
		step(asb_pkg::ASB_OP_CLEAR, 8'h00, 8'h39, 1'b1, 8'h00, 8'h1d);
		step(asb_pkg::ASB_OP_SWAP, 8'h00, 8'h31, 1'b1, 8'h13, 8'h1b);
		step(asb_pkg::ASB_OP_BITSET, 8'h00, 8'hfe, 1'b1, 8'hff, 8'hff);
		step(asb_pkg::ASB_OP_MOVE, 8'h00, 8'h55, 1'b1, 8'h00, 8'h18);
		step(asb_pkg::ASB_OP_AND, 8'h0f, 8'hf0, 1'b0, 8'h00, 8'h1c);
		step(asb_pkg::ASB_OP_IOR, 8'h0f, 8'hf0, 1'b0, 8'hff, 8'h18);
		step(asb_pkg::ASB_OP_BITCLR, 8'h00, 8'h01, 1'b0, 8'h00, 8'h18);
		step(asb_pkg::ASB_OP_ADD, 8'h80, 8'h80, 1'b0, 8'h00, 8'h1d);
		// Rotate into status: zero and digit carry keep their values
		step(asb_pkg::ASB_OP_ROTL, 8'h00, 8'h00, 1'b1, 8'h01, 8'h1c);
		step(asb_pkg::ASB_OP_ADD, 8'h80, 8'h80, 1'b0, 8'h00, 8'h1d);
		$display("test alu done");
	endtask

	task automatic t_events;
		ev(5'h02, 8'h15);
		wr(32'h0c, 32'h1d);
		#1 chk(status, 8'h15);
		ev(5'h04, 8'h05);
		ev(5'h01, 8'h1d);
		ev(5'h03, 8'h15);
		ev(5'h06, 8'h05);
		ev(5'h01, 8'h1d);
		$display("test events done");
	endtask

	task automatic t_other_reset;
		wr(32'h0c, 32'he3);
		wr(32'h28, 32'h15);
		ev(5'h08, 8'h1b);
		rd(32'h28, 32'h0);
		wr(32'h0c, 32'he0);
		master_clear_pin_n <= 1'b0;
		repeat (4) @(posedge hclk);
		master_clear_pin_n <= 1'b1;
		#1 chk(status, 8'h18);
		$display("test other_reset done");
	endtask

	task automatic t_banks;
		for (int i = 0; i < 4; i++) begin
			wr(32'h0c, {24'h0, i[0], i[1:0], 5'h00});
			core_dir_addr <= 7'h20;
			core_fsr <= 8'h40;
			repeat (2) @(posedge hclk);
			#1 chk(dmem_dir_addr, {i[1:0], 7'h20});
			chk(dmem_ind_addr, {i[0], 8'h40});
		end
		core_dir_addr <= 7'h05;
		core_fsr <= 8'h85;
		repeat (2) @(posedge hclk);
		#1 chk(dmem_dir_addr, 9'h005);
		chk(dmem_ind_addr, 9'h005);
		$display("test banks done");
	endtask

	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	// Whole run is under a hundred cycles; 5000 leaves ample margin
	initial begin
		#100000;
		error_cnt++;
		print_verdict();
	end

	initial begin
		error_cnt = 0;
		total_checks = 0;
		hresetn = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		master_clear_pin_n = 1'b1;
		core_dir_addr = 7'h00;
		core_fsr = 8'h00;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		t_reset_bus();
		t_alu();
		t_events();
		t_other_reset();
		t_banks();
		print_verdict();
	end
endmodule
